// ### verilog/ess_per_end.sv
`timescale 1ns/10ps
// ****************************************************************
// peripheral end: stalls processor timing and makes its own strobe
// ****************************************************************

// Overview of operation
// RULE_01 - processor loads registers only on strobe
// RULE_02 - processor strobes itself at third pulse normally
// RULE_03 - strobe is one 100 ns low pulse
// RULE_04 - data stable 280 ns before strobe
// RULE_05 - relative jumps need 400 ns data set-up
// RULE_06 - long set-up: stall timing, strobe locally
// RULE_07 - more-transfers low 50 ns before third pulse
// RULE_08 - processor halts at third pulse while low
// RULE_09 - resume needs line high plus a strobe
// RULE_10 - low line means strobe is not last
// RULE_11 - single transfers leave more-transfers line alone
// RULE_12 - multiple transfers stall until each finishes
// RULE_13 - adder carry ripple needs extra 120 ns
// RULE_14 - wait 400 ns, then strobe 100 ns
// RULE_15 - raise more-transfers before final strobe
// RULE_16 - final strobe restarts fourth state, ends pause
// RULE_17 - interrupt sampling comes from final strobe
// RULE_18 - hold data until final strobe ends
module ess_per_end (
  input  wire logic                  clk,
  input  wire logic                  reset,
  ess_bus_if.per_mp                  bus,
  input  wire logic                  xfer_valid,
  output logic                       xfer_ready,
  input  wire logic [ess_pkg::DATA_W-1:0] xfer_data,
  input  ess_pkg::ess_kind_t         xfer_kind,
  input  wire logic                  xfer_last,
  input  wire logic                  xfer_extend,
  output logic                       xfer_done,
  output logic                       xfer_abort,
  output logic                       busy
);
  import ess_pkg::*;

  typedef enum logic [2:0] {
    QS_IDLE     = 3'h0,
    QS_WAIT_IOT = 3'h1,
    QS_SIMPLE   = 3'h2,
    QS_SETUP    = 3'h3,
    QS_RELEASE  = 3'h4,
    QS_STROBE   = 3'h5,
    QS_NEXT     = 3'h6,
    QS_FINISH   = 3'h7
  } ess_qstate_t;

  typedef struct packed {
    ess_qstate_t       state;
    logic [CNT_W-1:0]  cnt;
    logic [DATA_W-1:0] data;
    ess_kind_t         kind;
    logic              last;
    logic              ext;
    logic              data_oe;
    logic              more_oe;
    logic              strobe_oe;
    logic              tp3_seen;
    logic              done;
    logic              abort;
  } ess_per_t;

  ess_per_t s_reg;
  ess_per_t s_next;
  logic     accept;
  logic     tp3_now;

  // a word is taken when idle, or between transfers of one instruction
  assign xfer_ready = (s_reg.state == QS_IDLE) || (s_reg.state == QS_NEXT);
  assign accept     = xfer_valid && xfer_ready;
  assign tp3_now    = s_reg.tp3_seen || bus.timing_pulse_three;

  // ****************************************************************
  // set-up time needed for a word
  // ****************************************************************
  // every kind gets carry ripple time on top of the normal set-up, not only the relative jump
  function automatic logic [CNT_W-1:0] ess_setup_cycles(input ess_kind_t kind);
    if (kind == ESS_KIND_PC_REL) begin
      ess_setup_cycles = EXT_SETUP_CYC; // [RULE_05] [RULE_13]
    end else begin
      ess_setup_cycles = (EXT_SETUP_CYC > NORMAL_SETUP_CYC) ? EXT_SETUP_CYC : NORMAL_SETUP_CYC; // [RULE_04] [RULE_14]
    end
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_next       = s_reg;
    s_next.done  = 1'b0;
    s_next.abort = 1'b0;
    unique case (s_reg.state)
      QS_IDLE: begin
        if (accept) begin
          s_next.state = QS_WAIT_IOT;
          s_next.data  = xfer_data;
          s_next.kind  = xfer_kind;
          s_next.last  = xfer_last;
          // anything beyond one plain transfer goes the extended way [RULE_06] [RULE_12]
          s_next.ext   = xfer_extend || (xfer_kind == ESS_KIND_PC_REL) || !xfer_last;
        end
      end
      QS_WAIT_IOT: begin
        if (!bus.io_pause_n) begin
          s_next.data_oe  = 1'b1;
          s_next.tp3_seen = 1'b0;
          if (s_reg.ext) begin
            // pause starts two full time states ahead of the third pulse [RULE_07]
            s_next.more_oe = 1'b1;
            s_next.cnt     = ess_setup_cycles(s_reg.kind);
            s_next.state   = QS_SETUP;
          end else begin
            s_next.state = QS_SIMPLE; // processor strobes itself [RULE_11] [RULE_02]
          end
        end
      end
      QS_SIMPLE: begin
        // end of pause means the processor strobe has come and gone
        if (bus.io_pause_n) begin
          s_next.data_oe = 1'b0;
          s_next.done    = 1'b1;
          s_next.state   = QS_IDLE;
        end
      end
      QS_SETUP: begin
        s_next.tp3_seen = tp3_now;
        if (s_reg.cnt > CNT_ONE) begin
          s_next.cnt = s_reg.cnt - CNT_ONE;
        end
        if (bus.io_pause_n && !s_reg.more_oe) begin
          // instruction ended under us; drop everything
          s_next.data_oe = 1'b0;
          s_next.abort   = 1'b1;
          s_next.state   = QS_IDLE;
        end else if (s_reg.cnt <= CNT_ONE && tp3_now) begin
          // strobe only once timing is stalled and data has settled [RULE_12] [RULE_14]
          if (s_reg.last) begin
            s_next.more_oe = 1'b0; // release before the final strobe [RULE_15]
            s_next.state   = QS_RELEASE;
          end else begin
            s_next.strobe_oe = 1'b1;
            s_next.cnt       = STROBE_CYC;
            s_next.state     = QS_STROBE;
          end
        end
      end
      QS_RELEASE: begin
        s_next.strobe_oe = 1'b1; // [RULE_06]
        s_next.cnt       = STROBE_CYC;
        s_next.state     = QS_STROBE;
      end
      QS_STROBE: begin
        s_next.cnt = s_reg.cnt - CNT_ONE;
        if (s_reg.cnt == CNT_ONE) begin
          s_next.strobe_oe = 1'b0; // low for exactly the strobe count [RULE_03] [RULE_14]
          s_next.done      = 1'b1;
          if (s_reg.last) begin
            s_next.data_oe = 1'b0; // release after the final strobe [RULE_18]
            s_next.state   = QS_FINISH;
          end else begin
            s_next.state = QS_NEXT; // line stays low, timing stays stalled [RULE_10]
          end
        end
      end
      QS_NEXT: begin
        // data stays driven while the next word is awaited [RULE_18]
        if (accept) begin
          s_next.data  = xfer_data;
          s_next.kind  = xfer_kind;
          s_next.last  = xfer_last;
          s_next.cnt   = ess_setup_cycles(xfer_kind);
          s_next.state = QS_SETUP;
        end
      end
      QS_FINISH: begin
        // processor resumes at the fourth state and ends the pause [RULE_16] [RULE_09]
        if (bus.io_pause_n) begin
          s_next.state = QS_IDLE;
        end
      end
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= '{state: QS_IDLE, cnt: CNT_RESET, data: DATA_RESET, kind: ESS_KIND_NONE, last: 1'b0,
                 ext: 1'b0, data_oe: 1'b0, more_oe: 1'b0, strobe_oe: 1'b0, tp3_seen: 1'b0,
                 done: 1'b0, abort: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // bus and user outputs
  // ****************************************************************
  assign bus.per_data_o    = s_reg.data;
  assign bus.per_data_oe   = s_reg.data_oe; // [RULE_04] [RULE_18]
  assign bus.per_kind      = s_reg.data_oe ? s_reg.kind : ESS_KIND_NONE;
  assign bus.per_strobe_o  = 1'b0;
  assign bus.per_strobe_oe = s_reg.strobe_oe; // [RULE_03]
  assign bus.per_more_o    = 1'b0;
  assign bus.per_more_oe   = s_reg.more_oe; // [RULE_07] [RULE_15]
  assign xfer_done         = s_reg.done;
  assign xfer_abort        = s_reg.abort;
  assign busy              = (s_reg.state != QS_IDLE);
endmodule

// ### shared/ess_pkg.sv
// ****************************************************************
// extended io strobe sequencer shared constants and types
// ****************************************************************
package ess_pkg;

  // bus and counter widths
  localparam int DATA_W = 12;
  localparam int CNT_W  = 5;

  // clock and bus timing figures, in nanoseconds
  localparam int CLK_PERIOD_NS   = 20;
  localparam int STROBE_NS       = 100;
  localparam int NORMAL_SETUP_NS = 280;
  localparam int CARRY_EXTRA_NS  = 120;
  localparam int REL_SETUP_NS    = 400;
  localparam int MT_LEAD_NS      = 50;
  localparam int TIME_STATE_NS   = 300;

  // cycle counts derived from the figures above (least times round up)
  localparam logic [CNT_W-1:0] STROBE_CYC =
    CNT_W'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] NORMAL_SETUP_CYC =
    CNT_W'((NORMAL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] EXT_SETUP_CYC =
    CNT_W'((NORMAL_SETUP_NS + CARRY_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] REL_SETUP_CYC =
    CNT_W'((REL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] MT_LEAD_CYC =
    CNT_W'((MT_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] TIME_STATE_CYC =
    CNT_W'(TIME_STATE_NS / CLK_PERIOD_NS);

  // values after reset, and the counter step of one
  localparam logic [DATA_W-1:0] AC_RESET   = 12'h000;
  localparam logic [DATA_W-1:0] PC_RESET   = 12'h000;
  localparam logic [DATA_W-1:0] DATA_RESET = 12'h000;
  localparam logic [CNT_W-1:0]  CNT_RESET  = 5'h00;
  localparam logic [CNT_W-1:0]  CNT_ONE    = 5'h01;

  // what the processor does with the data lines on a strobe
  typedef enum logic [1:0] {
    ESS_KIND_NONE   = 2'h0,
    ESS_KIND_AC_JAM = 2'h1,
    ESS_KIND_PC_ABS = 2'h2,
    ESS_KIND_PC_REL = 2'h3
  } ess_kind_t;

endpackage

// ### shared/ess_bus_if.sv
`timescale 1ns/10ps
// ****************************************************************
// backplane signals between processor end and peripheral end
// ****************************************************************
interface ess_bus_if;
  import ess_pkg::*;

  // peripheral drives
  logic [DATA_W-1:0] per_data_o;
  logic              per_data_oe;
  ess_kind_t         per_kind;
  logic              per_strobe_o;
  logic              per_strobe_oe;
  logic              per_more_o;
  logic              per_more_oe;

  // processor drives
  logic              proc_strobe_o;
  logic              proc_strobe_oe;
  logic              io_pause_n;
  logic              timing_pulse_three;
  logic              third_time_state;
  logic              fourth_time_state;

  // resolved wire levels (open-drain lines are a wired and)
  logic [DATA_W-1:0] data_lines;
  logic              load_strobe_n;
  logic              more_transfers_n;

  assign data_lines       = per_data_oe ? per_data_o : DATA_RESET;
  assign load_strobe_n    = ~((per_strobe_oe & ~per_strobe_o) | (proc_strobe_oe & ~proc_strobe_o));
  assign more_transfers_n = ~(per_more_oe & ~per_more_o);

  modport proc_mp (
    input  data_lines, load_strobe_n, more_transfers_n, per_kind,
    output proc_strobe_o, proc_strobe_oe, io_pause_n, timing_pulse_three,
           third_time_state, fourth_time_state
  );

  modport per_mp (
    input  load_strobe_n, more_transfers_n, io_pause_n, timing_pulse_three,
    output per_data_o, per_data_oe, per_kind, per_strobe_o, per_strobe_oe,
           per_more_o, per_more_oe
  );
endinterface

// ### verilog/ess_proc_end.sv
`timescale 1ns/10ps
// ****************************************************************
// processor end: timing chain, accumulator and program counter
// ****************************************************************
module ess_proc_end (
  input  wire logic                  clk,
  input  wire logic                  reset,
  ess_bus_if.proc_mp                 bus,
  input  wire logic                  io_start,
  output logic                       io_busy,
  output logic                       io_done,
  output logic                       int_strobe,
  output logic [ess_pkg::DATA_W-1:0] accumulator,
  output logic [ess_pkg::DATA_W-1:0] program_counter
);
  import ess_pkg::*;

  typedef enum logic [2:0] {
    PS_IDLE       = 3'h0,
    PS_TS1        = 3'h1,
    PS_TS2        = 3'h2,
    PS_TS3        = 3'h3,
    PS_STALL      = 3'h4,
    PS_STROBE_END = 3'h5,
    PS_TS4        = 3'h6
  } ess_pstate_t;

  typedef struct packed {
    ess_pstate_t       state;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  strobe_cnt;
    logic              io_pause;
    logic              tp3;
    logic              int_strobe;
    logic              done;
    logic              ls_prev;
    logic [DATA_W-1:0] ac;
    logic [DATA_W-1:0] pc;
  } ess_proc_t;

  ess_proc_t s_reg;
  ess_proc_t s_next;
  logic      ls_fall;

  // leading edge of the strobe line, whoever drives it
  assign ls_fall = s_reg.ls_prev & ~bus.load_strobe_n;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_next            = s_reg;
    s_next.tp3        = 1'b0;
    s_next.int_strobe = 1'b0;
    s_next.done       = 1'b0;
    s_next.ls_prev    = bus.load_strobe_n;
    if (s_reg.strobe_cnt != CNT_RESET) begin
      s_next.strobe_cnt = s_reg.strobe_cnt - CNT_ONE;
    end
    // registers load only on the strobe's leading edge [RULE_01]
    if (ls_fall && (s_reg.state == PS_TS3 || s_reg.state == PS_STALL || s_reg.state == PS_STROBE_END)) begin
      unique case (bus.per_kind)
        ESS_KIND_AC_JAM: s_next.ac = bus.data_lines;
        ESS_KIND_PC_ABS: s_next.pc = bus.data_lines;
        ESS_KIND_PC_REL: s_next.pc = s_reg.pc + bus.data_lines;
        ESS_KIND_NONE:   s_next.ac = s_reg.ac;
      endcase
    end
    unique case (s_reg.state)
      PS_IDLE: begin
        if (io_start) begin
          s_next.state = PS_TS1;
          s_next.cnt   = TIME_STATE_CYC;
        end
      end
      PS_TS1, PS_TS2: begin
        s_next.cnt = s_reg.cnt - CNT_ONE;
        if (s_reg.cnt == CNT_ONE) begin
          s_next.state    = (s_reg.state == PS_TS1) ? PS_TS2 : PS_TS3;
          s_next.cnt      = TIME_STATE_CYC;
          s_next.io_pause = 1'b1;
        end
      end
      PS_TS3: begin
        s_next.cnt = s_reg.cnt - CNT_ONE;
        if (s_reg.cnt == CNT_ONE) begin
          s_next.tp3 = 1'b1;
          if (bus.more_transfers_n) begin
            // own strobe at the third pulse, sampling interrupts [RULE_02] [RULE_03] [RULE_17]
            s_next.strobe_cnt = STROBE_CYC;
            s_next.int_strobe = 1'b1;
            s_next.state      = PS_STROBE_END;
          end else begin
            s_next.state = PS_STALL; // timing halts, third state stretches [RULE_08]
          end
        end
      end
      PS_STALL: begin
        // a strobe with the line low does not end the transaction [RULE_10]
        if (ls_fall && bus.more_transfers_n) begin
          s_next.int_strobe = 1'b1; // [RULE_17]
          s_next.state      = PS_STROBE_END; // [RULE_09]
        end
      end
      PS_STROBE_END: begin
        // restart at the fourth state once the strobe has ended [RULE_09] [RULE_16]
        if (s_reg.strobe_cnt == CNT_RESET && bus.load_strobe_n && bus.more_transfers_n) begin
          s_next.state    = PS_TS4;
          s_next.cnt      = TIME_STATE_CYC;
          s_next.io_pause = 1'b0; // [RULE_16]
        end
      end
      PS_TS4: begin
        s_next.cnt = s_reg.cnt - CNT_ONE;
        if (s_reg.cnt == CNT_ONE) begin
          s_next.state = PS_IDLE;
          s_next.done  = 1'b1;
        end
      end
      default: s_next.state = PS_IDLE;
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= '{state: PS_IDLE, cnt: CNT_RESET, strobe_cnt: CNT_RESET, io_pause: 1'b0, tp3: 1'b0,
                 int_strobe: 1'b0, done: 1'b0, ls_prev: 1'b1, ac: AC_RESET, pc: PC_RESET};
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs
  assign bus.proc_strobe_o      = 1'b0;
  assign bus.proc_strobe_oe     = (s_reg.strobe_cnt != CNT_RESET); // [RULE_03]
  assign bus.io_pause_n         = ~s_reg.io_pause;
  assign bus.timing_pulse_three = s_reg.tp3;
  assign bus.third_time_state   = (s_reg.state == PS_TS3) || (s_reg.state == PS_STALL)
                                  || (s_reg.state == PS_STROBE_END);
  assign bus.fourth_time_state  = (s_reg.state == PS_TS4);
  assign io_busy                = (s_reg.state != PS_IDLE);
  assign io_done                = s_reg.done;
  assign int_strobe             = s_reg.int_strobe;
  assign accumulator            = s_reg.ac;
  assign program_counter        = s_reg.pc;
endmodule

// ### verification/ess_monitor.sv
`timescale 1ns/10ps
// ****************************************************************
// protocol checks on the backplane between both ends
// ****************************************************************
module ess_monitor (
  input wire logic                       clk,
  input wire logic                       reset,
  input wire logic [ess_pkg::DATA_W-1:0] data_lines,
  input wire logic                       load_strobe_n,
  input wire logic                       more_transfers_n,
  input wire logic                       io_pause_n,
  input wire logic                       timing_pulse_three,
  input wire logic                       third_time_state,
  input wire logic                       fourth_time_state,
  input wire logic                       per_data_oe,
  input wire logic                       per_strobe_oe,
  input wire logic                       per_more_oe,
  input wire logic                       proc_strobe_oe
);
  import ess_pkg::*;

  logic [7:0]        stab_cnt_reg;
  logic [DATA_W-1:0] last_data_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // counts cycles the driven data has been unchanged
  always_ff @(posedge clk) begin
    if (reset || !per_data_oe) begin
      stab_cnt_reg <= 8'h00;
    end else if (stab_cnt_reg != 8'h00 && data_lines != last_data_reg) begin
      stab_cnt_reg <= 8'h01;
    end else if (stab_cnt_reg != 8'hff) begin
      stab_cnt_reg <= stab_cnt_reg + 8'h01;
    end
    last_data_reg <= data_lines;
  end

  a_strobe_width: assert property ($fell(load_strobe_n) |-> (!load_strobe_n)[*5] ##1 load_strobe_n)
    else $error("strobe pulse is not five cycles");
  a_own_strobe: assert property (timing_pulse_three && more_transfers_n && !io_pause_n |=> proc_strobe_oe)
    else $error("processor did not strobe after third pulse");
  a_stall_no_ts4: assert property (!more_transfers_n |=> !fourth_time_state)
    else $error("fourth state entered while more line low");
  a_resume_after_strobe: assert property ($rose(fourth_time_state) |-> more_transfers_n
    && ($past(load_strobe_n, 2) == 1'b0 || $past(load_strobe_n, 3) == 1'b0))
    else $error("timing resumed without a final strobe");
  a_strobe_in_ts3: assert property ($fell(load_strobe_n) |-> third_time_state)
    else $error("strobe outside third state");
  a_normal_setup: assert property ($fell(load_strobe_n) && per_data_oe |-> stab_cnt_reg >= 8'(NORMAL_SETUP_CYC))
    else $error("data set-up shorter than normal");
  a_ext_setup: assert property ($fell(load_strobe_n) && per_strobe_oe |-> stab_cnt_reg >= 8'(EXT_SETUP_CYC))
    else $error("extended data set-up too short");
  a_more_lead: assert property (timing_pulse_three && per_more_oe |-> $past(more_transfers_n, 3) == 1'b0)
    else $error("more line not low ahead of third pulse");
  a_data_held: assert property ($fell(load_strobe_n) && per_data_oe |-> (per_data_oe && $stable(data_lines))[*5])
    else $error("data not held through strobe");
  a_pause_ends: assert property ($rose(fourth_time_state) |-> ##[0:1] io_pause_n)
    else $error("pause not ended at fourth state");
endmodule

// ### verification/test_extended_io_strobe_sequencer.sv
`timescale 1ns/10ps
// ****************************************************************
// self-checking bench: both ends joined on one backplane
// ****************************************************************
module test_extended_io_strobe_sequencer;
  import ess_pkg::*;

  typedef struct {
    logic [DATA_W-1:0] ac;
    logic [DATA_W-1:0] pc;
    int                words;
  } ess_note_t;

  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic              io_start = 1'b0;
  logic              io_busy;
  logic              io_done;
  logic              int_strobe;
  logic [DATA_W-1:0] accumulator;
  logic [DATA_W-1:0] program_counter;
  logic              xfer_valid = 1'b0;
  logic              xfer_ready;
  logic [DATA_W-1:0] xfer_data = 12'h000;
  ess_kind_t         xfer_kind = ESS_KIND_NONE;
  logic              xfer_last = 1'b0;
  logic              xfer_extend = 1'b0;
  logic              xfer_done;
  logic              xfer_abort;
  logic              busy;
  int                error_cnt = 0;
  int                cmp_count = 0;
  int                cycles = 0;
  int                done_seen = 0;
  int                int_seen = 0;
  logic [DATA_W-1:0] model_ac = AC_RESET;
  logic [DATA_W-1:0] model_pc = PC_RESET;
  ess_note_t         notes[$];

  ess_bus_if bus_if();

  ess_proc_end i_ess_proc_end (.clk(clk), .reset(reset), .bus(bus_if), .io_start(io_start), .io_busy(io_busy),
    .io_done(io_done), .int_strobe(int_strobe), .accumulator(accumulator), .program_counter(program_counter));

  ess_per_end i_ess_per_end (.clk(clk), .reset(reset), .bus(bus_if), .xfer_valid(xfer_valid),
    .xfer_ready(xfer_ready), .xfer_data(xfer_data), .xfer_kind(xfer_kind), .xfer_last(xfer_last),
    .xfer_extend(xfer_extend), .xfer_done(xfer_done), .xfer_abort(xfer_abort), .busy(busy));

  ess_monitor u_mon (.clk(clk), .reset(reset), .data_lines(bus_if.data_lines),
    .load_strobe_n(bus_if.load_strobe_n), .more_transfers_n(bus_if.more_transfers_n),
    .io_pause_n(bus_if.io_pause_n), .timing_pulse_three(bus_if.timing_pulse_three),
    .third_time_state(bus_if.third_time_state), .fourth_time_state(bus_if.fourth_time_state),
    .per_data_oe(bus_if.per_data_oe), .per_strobe_oe(bus_if.per_strobe_oe),
    .per_more_oe(bus_if.per_more_oe), .proc_strobe_oe(bus_if.proc_strobe_oe));

  // 50 mhz clock
  always #10 clk = ~clk;

  // ****************************************************************
  // compare and report
  // ****************************************************************
  task automatic check_reg(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_cnt(input string name, input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("[FAIL] run time expected under 20000 cycles seen %0d", cycles);
      results();
    end
  end

  // watcher: counts pulses and checks registers at end of each instruction
  always @(posedge clk) begin
    ess_note_t n;
    if (xfer_done === 1'b1) done_seen++;
    if (int_strobe === 1'b1) int_seen++;
    if (xfer_abort === 1'b1) check_cnt("xfer_abort", 0, 1);
    if (io_done === 1'b1) begin
      if (notes.size() == 0) begin
        check_cnt("unexpected io_done", 0, 1);
      end else begin
        n = notes.pop_front();
        check_reg("accumulator", n.ac, accumulator);
        check_reg("program_counter", n.pc, program_counter);
        check_cnt("xfer_done pulses", n.words, done_seen);
        check_cnt("int_strobe pulses", 1, int_seen);
        check_reg("io_busy", 12'h000, {11'h000, io_busy});
        check_reg("busy", 12'h000, {11'h000, busy});
      end
      done_seen = 0;
      int_seen = 0;
    end
  end

  // ****************************************************************
  // driver
  // ****************************************************************
  task automatic send_word(input logic [DATA_W-1:0] d, input ess_kind_t k, input logic lst, input logic ext);
    int n;
    n = 0;
    xfer_valid <= 1'b1;
    xfer_data <= d;
    xfer_kind <= k;
    xfer_last <= lst;
    xfer_extend <= ext;
    @(posedge clk);
    while (xfer_ready !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    xfer_valid <= 1'b0;
    @(posedge clk);
  endtask

  // one instruction of nw words; kinds and data from the tables
  task automatic run_instr(input int nw, input ess_kind_t ks[3], input logic [DATA_W-1:0] ds[3], input logic ext);
    ess_note_t n;
    int        w;
    for (w = 0; w < nw; w++) begin
      case (ks[w])
        ESS_KIND_AC_JAM: model_ac = ds[w];
        ESS_KIND_PC_ABS: model_pc = ds[w];
        ESS_KIND_PC_REL: model_pc = model_pc + ds[w];
        default: ;
      endcase
    end
    n.ac = model_ac;
    n.pc = model_pc;
    n.words = nw;
    notes.push_back(n);
    send_word(ds[0], ks[0], 1'(nw == 1), ext || nw > 1);
    io_start <= 1'b1;
    @(posedge clk);
    io_start <= 1'b0;
    for (w = 1; w < nw; w++) begin
      send_word(ds[w], ks[w], 1'(w == nw - 1), 1'b1);
    end
    w = 0;
    while (io_done !== 1'b1 && w < 400) begin
      @(posedge clk);
      w++;
    end
    repeat (3) @(posedge clk);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    ess_kind_t         ks[3];
    logic [DATA_W-1:0] ds[3];
    int                t;
    int                nw;
    logic              ext;
    void'($urandom(29));
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // directed: jam and absolute kinds plain then extended, relative jump extended both times, then random mixes of one to three words
    for (t = 0; t < 14; t++) begin
      ds[0] = 12'($urandom);
      ds[1] = 12'($urandom);
      ds[2] = 12'($urandom);
      if (t < 6) begin
        nw = 1;
        ks[0] = ess_kind_t'(2'(t % 3 + 1));
        ext = 1'(t / 3);
      end else begin
        nw = int'($urandom_range(3, 1));
        ks[0] = ess_kind_t'(2'($urandom_range(3, 0)));
        ks[1] = ess_kind_t'(2'($urandom_range(3, 0)));
        ks[2] = ess_kind_t'(2'($urandom_range(3, 0)));
        ext = 1'($urandom_range(1, 0));
      end
      run_instr(nw, ks, ds, ext);
      $display("test %0d finished with %0d words", t, nw);
    end
    check_cnt("notes left", 0, notes.size());
    results();
  end
endmodule
